/* cbd_pkg.sv */
`default_nettype none

package cbd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] CBD_OFS_GEN_CFG   = 16'h0180;
    localparam logic [15:0] CBD_OFS_LINK_CTRL = 16'h01a7;
    localparam logic [15:0] CBD_OFS_IRQ_STAT  = 16'h01a8;
    localparam logic [15:0] CBD_OFS_IRQ_MASK  = 16'h01a9;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CBD_POS_CD_SKIP    = 12;
    localparam int CBD_POS_CROSS_OFF  = 11;
    localparam int CBD_POS_IDLE_CHK   = 10;
    localparam int CBD_POS_AVG_LO     = 7;
    localparam int CBD_POS_SEG_LO     = 4;
    localparam int CBD_POS_CYC_LO     = 0;
    localparam int CBD_POS_RESULT_LO  = 8;
    localparam int CBD_POS_DONE       = 5;
    localparam int CBD_POS_CLEAR      = 4;

    // ------------------------------------------------------------------
    // Reset values and reserved codes
    // ------------------------------------------------------------------
    localparam logic       CBD_RST_CD_SKIP   = 1'b0;
    localparam logic       CBD_RST_CROSS_OFF = 1'b0;
    localparam logic       CBD_RST_IDLE_CHK  = 1'b1;
    localparam logic [2:0] CBD_RST_AVG       = 3'h6;
    localparam logic [2:0] CBD_RST_SEG       = 3'h5;
    localparam logic [3:0] CBD_RST_CYC       = 4'h2;
    localparam logic [7:0] CBD_RST_RESULT    = 8'h00;
    localparam logic [2:0] CBD_AVG_RESERVED  = 3'h7;

    // ------------------------------------------------------------------
    // Timing: one microsecond of cycle duration in clock cycles
    // ------------------------------------------------------------------
    localparam int          CBD_US_NS         = 1000;
    localparam int          CBD_CLK_PERIOD_NS = 5;
    localparam logic [11:0] CBD_CLKS_PER_US   = 12'(CBD_US_NS / CBD_CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    localparam int CBD_IRQ_W       = 2;
    localparam int CBD_IRQ_DONE    = 0;
    localparam int CBD_IRQ_CLEARED = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CBD_ST_IDLE = 2'b01,
        CBD_ST_RUN  = 2'b10
    } cbd_state_t;

    // Settings handed to the reflectometry engine for one measurement.
    typedef struct packed {
        logic        pairs_cd_skip;
        logic        cross_pair_listen_off;
        logic        idle_pulse_check;
        logic [6:0]  avg_cycles;
        logic [2:0]  segment_count;
        logic [11:0] cycle_clocks;
    } cbd_meas_cfg_t;

    // Whole state of the control block.
    typedef struct packed {
        cbd_state_t    st;
        logic          cd_skip;
        logic          cross_off;
        logic          idle_chk;
        logic [2:0]    avg;
        logic [2:0]    seg;
        logic [3:0]    cyc;
        logic          clr_pend;
        logic [7:0]    result;
        logic          done;
        cbd_meas_cfg_t act;
        logic [15:0]   rdata;
    } cbd_ctrl_state_t;

    // Whole state of the event flag unit.
    typedef struct packed {
        logic [CBD_IRQ_W-1:0] status;
        logic [CBD_IRQ_W-1:0] mask;
    } cbd_flag_state_t;

    // Turns an averaging code into a number of cycles; the reserved code gives zero.
    function automatic logic [6:0] cbd_avg_cycles_f(input logic [2:0] code);
        logic [6:0] n;
        n = 7'h00;
        if (code != CBD_AVG_RESERVED) begin
            n = 7'h01 << code;
        end
        return n;
    endfunction : cbd_avg_cycles_f

endpackage : cbd_pkg

`default_nettype wire

/* cbd_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module cbd_event_flags (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         resetn_in,
    // Events and register access
    input  wire logic [cbd_pkg::CBD_IRQ_W-1:0] event_in,
    input  wire logic                         stat_rd_in,
    input  wire logic                         mask_wr_in,
    input  wire logic [cbd_pkg::CBD_IRQ_W-1:0] mask_data_in,
    // Results
    output logic      [cbd_pkg::CBD_IRQ_W-1:0] status_out,
    output logic      [cbd_pkg::CBD_IRQ_W-1:0] mask_out,
    output logic                              irq_out
);

    cbd_pkg::cbd_flag_state_t        q;
    cbd_pkg::cbd_flag_state_t        d;
    logic [cbd_pkg::CBD_IRQ_W-1:0]   stat_next;

    // Each flag is sticky; a read clears it, but a new event in the same cycle wins.
    for (genvar i = 0; i < cbd_pkg::CBD_IRQ_W; i++) begin : g_flag
        assign stat_next[i] = event_in[i] | (q.status[i] & ~stat_rd_in);
    end

    // Next state.
    always_comb begin
        d        = q;
        d.status = stat_next;
        if (mask_wr_in) begin
            d.mask = mask_data_in;
        end
    end

    // State register.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // The interrupt stays high while any unmasked flag is set.
    assign status_out = q.status;
    assign mask_out   = q.mask;
    assign irq_out    = |(q.status & q.mask);

    chk_flag_sticky : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (|event_in) |=> ((q.status & $past(event_in)) == $past(event_in)))
        else $error("event flag not set after event");

endmodule : cbd_event_flags

`default_nettype wire

/* cbd_diag_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module cbd_diag_ctrl (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    // Register port
    input  wire logic [15:0]           reg_addr_in,
    input  wire logic [15:0]           reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [15:0]           reg_rdata_out,
    // Reflectometry engine
    input  wire logic                  meas_start_in,
    input  wire logic                  diag_done_in,
    input  wire logic [7:0]            diag_result_in,
    output var cbd_pkg::cbd_meas_cfg_t meas_cfg_out,
    output logic                       meas_busy_out,
    output logic                       result_clear_out,
    // Interrupt
    output logic                       irq_out
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    cbd_pkg::cbd_ctrl_state_t          q;
    cbd_pkg::cbd_ctrl_state_t          d;
    logic                              wr_gen;
    logic                              wr_link;
    logic                              wr_mask;
    logic                              rd_stat;
    logic [2:0]                        wr_avg;
    logic [cbd_pkg::CBD_IRQ_W-1:0]     irq_events;
    logic [cbd_pkg::CBD_IRQ_W-1:0]     irq_status;
    logic [cbd_pkg::CBD_IRQ_W-1:0]     irq_mask;
    logic                              start_take;

    // Matches one register offset against the access address.
    function automatic logic hit_f(input logic [15:0] addr, input logic [15:0] ofs);
        return addr == ofs;
    endfunction : hit_f

    // Strobe decode for each register.
    assign wr_gen  = reg_wr_in && hit_f(reg_addr_in, cbd_pkg::CBD_OFS_GEN_CFG);
    assign wr_link = reg_wr_in && hit_f(reg_addr_in, cbd_pkg::CBD_OFS_LINK_CTRL);
    assign wr_mask = reg_wr_in && hit_f(reg_addr_in, cbd_pkg::CBD_OFS_IRQ_MASK);
    assign rd_stat = reg_rd_in && hit_f(reg_addr_in, cbd_pkg::CBD_OFS_IRQ_STAT);
    assign wr_avg  = reg_wdata_in[cbd_pkg::CBD_POS_AVG_LO +: 3];

    // A start is only taken while no measurement runs.
    assign start_take = meas_start_in && (q.st == cbd_pkg::CBD_ST_IDLE);

    // Events: a result arrives, or a clear request has been carried out.
    assign irq_events[cbd_pkg::CBD_IRQ_DONE]    = diag_done_in;
    assign irq_events[cbd_pkg::CBD_IRQ_CLEARED] = q.clr_pend;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;

        // Configuration writes; reserved bits are simply not stored.
        if (wr_gen) begin
            d.cd_skip   = reg_wdata_in[cbd_pkg::CBD_POS_CD_SKIP];
            d.cross_off = reg_wdata_in[cbd_pkg::CBD_POS_CROSS_OFF];
            d.idle_chk  = reg_wdata_in[cbd_pkg::CBD_POS_IDLE_CHK];
            d.seg       = reg_wdata_in[cbd_pkg::CBD_POS_SEG_LO +: 3];
            d.cyc       = reg_wdata_in[cbd_pkg::CBD_POS_CYC_LO +: 4];
            if (wr_avg != cbd_pkg::CBD_AVG_RESERVED) begin
                d.avg = wr_avg;
            end
        end

        // The clear bit lives for one cycle and then drops by itself.
        d.clr_pend = wr_link && reg_wdata_in[cbd_pkg::CBD_POS_CLEAR];
        if (q.clr_pend) begin
            d.result = cbd_pkg::CBD_RST_RESULT;
            d.done   = 1'b0;
        end

        // A finished measurement wins over a clear in the same cycle.
        if (diag_done_in) begin
            d.result = diag_result_in;
            d.done   = 1'b1;
        end

        // Measurement sequencing; settings are frozen for the whole run.
        unique case (q.st)
            cbd_pkg::CBD_ST_IDLE: begin
                if (start_take) begin
                    d.st                          = cbd_pkg::CBD_ST_RUN;
                    d.act.pairs_cd_skip           = q.cd_skip;
                    d.act.cross_pair_listen_off   = q.cross_off;
                    d.act.idle_pulse_check        = q.idle_chk;
                    d.act.avg_cycles              = cbd_pkg::cbd_avg_cycles_f(q.avg);
                    d.act.segment_count           = q.seg;
                    d.act.cycle_clocks            = 12'(q.cyc) * cbd_pkg::CBD_CLKS_PER_US;
                end
            end
            cbd_pkg::CBD_ST_RUN: begin
                if (diag_done_in) begin
                    d.st = cbd_pkg::CBD_ST_IDLE;
                end
            end
            default: begin
                d.st = cbd_pkg::CBD_ST_IDLE;
            end
        endcase

        // Read data stand in the cycle after the read strobe only.
        d.rdata = 16'h0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                cbd_pkg::CBD_OFS_GEN_CFG: begin
                    d.rdata[cbd_pkg::CBD_POS_CD_SKIP]     = q.cd_skip;
                    d.rdata[cbd_pkg::CBD_POS_CROSS_OFF]   = q.cross_off;
                    d.rdata[cbd_pkg::CBD_POS_IDLE_CHK]    = q.idle_chk;
                    if (q.avg != cbd_pkg::CBD_AVG_RESERVED) begin
                        d.rdata[cbd_pkg::CBD_POS_AVG_LO +: 3] = q.avg;
                    end
                    d.rdata[cbd_pkg::CBD_POS_SEG_LO +: 3] = q.seg;
                    d.rdata[cbd_pkg::CBD_POS_CYC_LO +: 4] = q.cyc;
                end
                cbd_pkg::CBD_OFS_LINK_CTRL: begin
                    d.rdata[cbd_pkg::CBD_POS_RESULT_LO +: 8] = q.result;
                    d.rdata[cbd_pkg::CBD_POS_DONE]           = q.done;
                    d.rdata[cbd_pkg::CBD_POS_CLEAR]          = q.clr_pend;
                end
                cbd_pkg::CBD_OFS_IRQ_STAT: begin
                    d.rdata[cbd_pkg::CBD_IRQ_W-1:0] = irq_status;
                end
                cbd_pkg::CBD_OFS_IRQ_MASK: begin
                    d.rdata[cbd_pkg::CBD_IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    d.rdata = 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            q.st        <= cbd_pkg::CBD_ST_IDLE;
            q.cd_skip   <= cbd_pkg::CBD_RST_CD_SKIP;
            q.cross_off <= cbd_pkg::CBD_RST_CROSS_OFF;
            q.idle_chk  <= cbd_pkg::CBD_RST_IDLE_CHK;
            q.avg       <= cbd_pkg::CBD_RST_AVG;
            q.seg       <= cbd_pkg::CBD_RST_SEG;
            q.cyc       <= cbd_pkg::CBD_RST_CYC;
            q.clr_pend  <= 1'b0;
            q.result    <= cbd_pkg::CBD_RST_RESULT;
            q.done      <= 1'b0;
            q.act       <= '0;
            q.rdata     <= 16'h0000;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------------
    cbd_event_flags u_flags (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .event_in     (irq_events),
        .stat_rd_in   (rd_stat),
        .mask_wr_in   (wr_mask),
        .mask_data_in (reg_wdata_in[cbd_pkg::CBD_IRQ_W-1:0]),
        .status_out   (irq_status),
        .mask_out     (irq_mask),
        .irq_out      (irq_out)
    );

    // Outputs come straight from the state register.
    assign reg_rdata_out    = q.rdata;
    assign meas_cfg_out     = q.act;
    assign meas_busy_out    = (q.st == cbd_pkg::CBD_ST_RUN);
    assign result_clear_out = q.clr_pend;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_start;
        start_take;
    endsequence

    sequence s_clear_req;
        wr_link && reg_wdata_in[cbd_pkg::CBD_POS_CLEAR];
    endsequence

    sequence s_gen_write;
        wr_gen;
    endsequence

    chk_cd_skip_latch : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_start |=> (meas_cfg_out.pairs_cd_skip == $past(q.cd_skip)) && meas_busy_out)
        else $error("pair C/D skip not handed to the engine at start");

    chk_cross_off_latch : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_start |=> meas_cfg_out.cross_pair_listen_off == $past(q.cross_off))
        else $error("cross-pair listen setting not handed over at start");

    chk_idle_chk_reset : assert property (@(posedge clk_in)
        !resetn_in |=> q.idle_chk && (q.avg == cbd_pkg::CBD_RST_AVG))
        else $error("idle pulse check or averaging wrong after reset");

    chk_avg_decode : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_start |=> meas_cfg_out.avg_cycles == cbd_pkg::cbd_avg_cycles_f($past(q.avg)))
        else $error("averaging cycles decoded wrongly");

    chk_avg_reserved : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_gen_write and (wr_avg == cbd_pkg::CBD_AVG_RESERVED)) |=> $stable(q.avg))
        else $error("reserved averaging code was stored");

    chk_seg_write : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_gen_write |=> q.seg == $past(reg_wdata_in[cbd_pkg::CBD_POS_SEG_LO +: 3]))
        else $error("segment count not taken from write");

    chk_cycle_clocks : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_start |=> meas_cfg_out.cycle_clocks == 12'($past(q.cyc)) * cbd_pkg::CBD_CLKS_PER_US)
        else $error("cycle duration not scaled to clock cycles");

    chk_done_result : assert property (@(posedge clk_in) disable iff (!resetn_in)
        diag_done_in |=> q.done && (q.result == $past(diag_result_in)))
        else $error("result or done flag not captured");

    chk_clear_seq : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_clear_req ##1 !diag_done_in) |=> !q.done && (q.result == 8'h00) &&
            (q.clr_pend == $past(wr_link && reg_wdata_in[cbd_pkg::CBD_POS_CLEAR])))
        else $error("clear did not wipe result or did not drop itself");

    chk_cfg_frozen : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (meas_busy_out && !diag_done_in) |=> $stable(meas_cfg_out))
        else $error("settings changed during a running measurement");

    chk_rsvd_read : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (reg_rd_in && reg_addr_in == cbd_pkg::CBD_OFS_LINK_CTRL) |=>
            (reg_rdata_out[7:6] == 2'h0) && (reg_rdata_out[3:0] == 4'h0))
        else $error("reserved bits read nonzero");

    // The top three bits of the general settings word never read back as one.
    chk_gen_rsvd_read : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (reg_rd_in && reg_addr_in == cbd_pkg::CBD_OFS_GEN_CFG) |=>
            (reg_rdata_out[15:13] == 3'h0))
        else $error("reserved settings bits read nonzero");

    // Without a read strobe the read data fall back to zero.
    chk_rdata_quiet : assert property (@(posedge clk_in) disable iff (!resetn_in)
        !reg_rd_in |=> (reg_rdata_out == 16'h0000))
        else $error("read data stood without a read");

    // A clear request shows up on the clear output one cycle later.
    chk_clear_pulse : assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_clear_req |=> result_clear_out)
        else $error("clear pulse missing after clear write");

    // A finished measurement drops the busy indication.
    chk_done_ends : assert property (@(posedge clk_in) disable iff (!resetn_in)
        (meas_busy_out && diag_done_in) |=> !meas_busy_out)
        else $error("measurement still busy after done");

endmodule : cbd_diag_ctrl

`default_nettype wire

/* cbd_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural reflectometry engine: starts on command, ends after a chosen delay.
module cbd_engine_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    // Commands from the bench
    input  wire logic       go_in,
    input  wire logic [7:0] delay_in,
    input  wire logic [7:0] result_in,
    // Engine side of the block
    output logic            meas_start_out,
    output logic            diag_done_out,
    output logic      [7:0] diag_result_out
);
    logic       run_q;
    logic [7:0] cnt_q;
    logic [7:0] res_q;

    // A start on every command; a new command reloads the delay even mid-run.
    always @(posedge clk_in) begin
        if (!resetn_in) begin
            meas_start_out  <= 1'b0;
            diag_done_out   <= 1'b0;
            diag_result_out <= 8'h5a;
            run_q           <= 1'b0;
            cnt_q           <= 8'h00;
            res_q           <= 8'h00;
        end else begin
            meas_start_out  <= go_in;
            diag_done_out   <= 1'b0;
            diag_result_out <= ~diag_result_out;  // Result is only valid with the done pulse.
            if (go_in) begin
                run_q <= 1'b1;
                cnt_q <= delay_in;
                res_q <= result_in;
            end else if (run_q && cnt_q == 8'h00) begin
                diag_done_out   <= 1'b1;
                diag_result_out <= res_q;
                run_q           <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : cbd_engine_model

`default_nettype wire

/* cbd_diag_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module cbd_diag_ctrl_tb;
    logic                   clk_in, resetn_in, reg_wr_in, reg_rd_in, go;
    logic            [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd, wv;
    logic                   meas_start_in, diag_done_in, meas_busy_out, result_clear_out, irq_out;
    logic             [7:0] diag_result_in, go_delay, go_result;
    logic             [2:0] code;
    cbd_pkg::cbd_meas_cfg_t meas_cfg_out, exp_cfg;
    int                     fails, samples_checked, cycles, c;

    cbd_diag_ctrl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .meas_start_in(meas_start_in),
        .diag_done_in(diag_done_in), .diag_result_in(diag_result_in),
        .meas_cfg_out(meas_cfg_out), .meas_busy_out(meas_busy_out),
        .result_clear_out(result_clear_out), .irq_out(irq_out));

    cbd_engine_model i_eng (.clk_in(clk_in), .resetn_in(resetn_in), .go_in(go),
        .delay_in(go_delay), .result_in(go_result), .meas_start_out(meas_start_in),
        .diag_done_out(diag_done_in), .diag_result_out(diag_result_in));

    // 200 MHz clock.
    always #2.5 clk_in = ~clk_in;

    // Cuts a hung run short.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe.
    task automatic read_check(input logic [15:0] a, input logic [15:0] e, input string name);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        check(name, 32'(reg_rdata_out), 32'(e));
    endtask : read_check

    // Commands a start and waits for the block to report busy.
    task automatic run_start(input logic [7:0] d, input logic [7:0] r);
        int i;
        @(posedge clk_in);
        go        <= 1'b1;
        go_delay  <= d;
        go_result <= r;
        @(posedge clk_in);
        go        <= 1'b0;
        @(posedge clk_in);
        #1;
        for (i = 0; i < 8 && meas_busy_out !== 1'b1; i++) begin
            @(posedge clk_in);
            #1;
        end
        check("busy", 32'(meas_busy_out), 32'h1);
    endtask : run_start

    task automatic wait_idle();
        int i;
        for (i = 0; i < 300 && meas_busy_out !== 1'b0; i++) begin
            @(posedge clk_in);
            #1;
        end
        check("idle", 32'(meas_busy_out), 32'h0);
    endtask : wait_idle

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        clk_in = 0;
        resetn_in = 0;
        reg_wr_in = 0;
        reg_rd_in = 0;
        reg_addr_in = 16'h0000;
        reg_wdata_in = 16'h0000;
        go = 0;
        go_delay = 8'h00;
        go_result = 8'h00;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        read_check(cbd_pkg::CBD_OFS_GEN_CFG, 16'h0752, "gen_rst");
        read_check(cbd_pkg::CBD_OFS_LINK_CTRL, 16'h0000, "link_rst");
        read_check(cbd_pkg::CBD_OFS_IRQ_MASK, 16'h0000, "mask_rst");
        read_check(16'h0181, 16'h0000, "unmapped");
        $display("test reset_values done");
        // Every writable bit set; reserved averaging code must be dropped.
        reg_write(cbd_pkg::CBD_OFS_GEN_CFG, 16'hffff);
        read_check(cbd_pkg::CBD_OFS_GEN_CFG, 16'h1f7f, "gen_ones");
        $display("test all_ones done");
        // Each legal averaging code through a whole measurement.
        for (c = 0; c < 7; c++) begin
            code = 3'(c);
            wv = 16'({code[0], code[1], code[2], code, code, 4'(2 * c + 1)});
            reg_write(cbd_pkg::CBD_OFS_GEN_CFG, wv);
            read_check(cbd_pkg::CBD_OFS_GEN_CFG, wv, "gen_code");
            exp_cfg.pairs_cd_skip = code[0];
            exp_cfg.cross_pair_listen_off = code[1];
            exp_cfg.idle_pulse_check = code[2];
            exp_cfg.avg_cycles = 7'h01 << code;
            exp_cfg.segment_count = code;
            exp_cfg.cycle_clocks = 12'(2 * c + 1) * cbd_pkg::CBD_CLKS_PER_US;
            run_start(8'(9 * c), 8'(8'h30 + c));
            check("cfg", 32'(meas_cfg_out), 32'(exp_cfg));
            wait_idle();
            read_check(cbd_pkg::CBD_OFS_LINK_CTRL, {8'(8'h30 + c), 8'h20}, "result");
        end
        check("irq_masked", 32'(irq_out), 32'h0);
        read_check(cbd_pkg::CBD_OFS_IRQ_STAT, 16'h0001, "stat_done");
        read_check(cbd_pkg::CBD_OFS_IRQ_STAT, 16'h0000, "stat_read_clr");
        $display("test averaging_codes done");
        // Reserved averaging code beside other fields: only the others land.
        reg_write(cbd_pkg::CBD_OFS_GEN_CFG, 16'h03a5);
        read_check(cbd_pkg::CBD_OFS_GEN_CFG, 16'h0325, "gen_rsvd");
        exp_cfg = '{1'b0, 1'b0, 1'b0, 7'h40, 3'h2, 12'h3e8};
        run_start(8'h3c, 8'hc3);
        check("cfg_run", 32'(meas_cfg_out), 32'(exp_cfg));
        reg_write(cbd_pkg::CBD_OFS_GEN_CFG, 16'h1c11);
        run_start(8'h04, 8'hc3);
        check("cfg_held", 32'(meas_cfg_out), 32'(exp_cfg));
        wait_idle();
        run_start(8'h02, 8'h3c);
        exp_cfg = '{1'b1, 1'b1, 1'b1, 7'h01, 3'h1, 12'h0c8};
        check("cfg_next", 32'(meas_cfg_out), 32'(exp_cfg));
        wait_idle();
        $display("test frozen_settings done");
        // Interrupt unmasked, read-only bits, then the self-clearing clear.
        reg_write(cbd_pkg::CBD_OFS_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge clk_in);
        #1;
        check("irq_on", 32'(irq_out), 32'h1);
        read_check(cbd_pkg::CBD_OFS_IRQ_STAT, 16'h0001, "stat_run");
        repeat (2) @(posedge clk_in);
        #1;
        check("irq_off", 32'(irq_out), 32'h0);
        reg_write(cbd_pkg::CBD_OFS_LINK_CTRL, 16'hffef);
        read_check(cbd_pkg::CBD_OFS_LINK_CTRL, 16'h3c20, "link_ro");
        reg_write(cbd_pkg::CBD_OFS_LINK_CTRL, 16'h0010);
        #1;
        check("clr_pulse", 32'(result_clear_out), 32'h1);
        @(posedge clk_in);
        #1;
        check("clr_end", 32'(result_clear_out), 32'h0);
        check("irq_clr", 32'(irq_out), 32'h1);
        read_check(cbd_pkg::CBD_OFS_LINK_CTRL, 16'h0000, "link_clr");
        read_check(cbd_pkg::CBD_OFS_IRQ_STAT, 16'h0002, "stat_clr");
        $display("test clear_and_irq done");
        summarize();
    end
endmodule : cbd_diag_ctrl_tb

`default_nettype wire
